// file: rtl/sensor_eeprom_pkg.sv
package sensor_eeprom_pkg;

   // bus type codes (upper four address bits)
   localparam logic [3:0]  TYPE_SENSOR       = 4'h3;
   localparam logic [3:0]  TYPE_MEM          = 4'ha;
   localparam logic [3:0]  TYPE_PROT         = 4'h6;

   // memory array and lower-half lock
   localparam int          MEM_DEPTH         = 256;
   localparam logic [7:0]  LOCK_TOP          = 8'h7f;
   localparam logic        MEM_WRITE_CONTROL = 1'b0;

   // protection commands: first data byte written to the protection target
   localparam logic [7:0]  PROT_SET_REV      = 8'h01;
   localparam logic [7:0]  PROT_SET_PERM     = 8'h02;
   localparam logic [7:0]  PROT_CLEAR        = 8'h03;

   // sensor register pointers
   localparam logic [7:0]  PTR_CONFIG        = 8'h01;
   localparam logic [7:0]  PTR_UPPER         = 8'h02;
   localparam logic [7:0]  PTR_LOWER         = 8'h03;
   localparam logic [7:0]  PTR_CRIT          = 8'h04;
   localparam logic [7:0]  PTR_TEMP          = 8'h05;

   // sensor configuration word
   localparam int          CFG_INT_MODE      = 0;
   localparam int          CFG_CRIT_ONLY     = 2;
   localparam int          CFG_EVT_EN        = 3;
   localparam int          CFG_EVT_CLEAR     = 5;
   localparam logic [15:0] CFG_RESET         = 16'h0008;
   localparam logic [15:0] CFG_WMASK         = 16'h000d;
   localparam logic [9:0]  LIMIT_RESET       = 10'h000;

   // avalon register map (byte addresses)
   localparam int          AV_AW             = 4;
   localparam logic [3:0]  REG_STATUS        = 4'h0;
   localparam logic [3:0]  REG_MASK          = 4'h4;
   localparam logic [3:0]  REG_TEMP          = 4'h8;
   localparam logic [3:0]  REG_STATE         = 4'hc;

   // status and mask bits
   localparam int          ST_W              = 3;
   localparam int          ST_ALERT          = 0;
   localparam int          ST_REJECT         = 1;
   localparam int          ST_PROT           = 2;
   localparam logic [9:0]  TEMP_RESET        = 10'h000;

   typedef enum logic [1:0] {TGT_SENSOR, TGT_MEM, TGT_PROT} target_t;

endpackage

// file: rtl/pin_filter.sv
`timescale 1ns/10ps
module pin_filter #(
   parameter int           W    = 1,
   parameter logic [W-1:0] INIT = '1
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   // s1 feeds only s2; a bit changes once s2 and s3 agree
   always_ff @(posedge clk) begin
      if (!rstn) begin
         s1   <= INIT;
         s2   <= INIT;
         s3   <= INIT;
         dout <= INIT;
      end else begin
         s1   <= din;
         s2   <= s1;
         s3   <= s2;
         dout <= (s2 & s3) | (dout & (s2 ^ s3)) | (~(s2 ^ s3) & s3);
      end
   end
endmodule

// file: rtl/sensor_eeprom_bus_decode.sv
`timescale 1ns/10ps
// What this block does
// - code 0011 selects sensor registers
// - code 1010 selects the memory array
// - code 0110 selects write-protection settings
// - address is type code plus three bits
// - memory holds 256 bytes, 8-bit address
// - lower 128 bytes can be write-locked
// - command locks lower half, permanent or reversible
// - write-control input treated as always low
// - alert on over-limit or outside window
// - option: alert shows critical condition only
// - alert runs as comparator or interrupt
// - temperature is 10 bits, quarter degree
// - temperature kept in Celsius only
// - memory and temperature readable any time
// - serial logic works up to 400 kHz
// - three strap pins give low address bits
// - alert pin is active-low open drain
module sensor_eeprom_bus_decode (
   input  wire logic                                clk,
   input  wire logic                                rstn,
   input  wire logic                                scl,
   input  wire logic                                sdaIn,
   output logic                                     sdaOut,
   output logic                                     sdaOe,
   input  wire logic                                addrSelectBit0,
   input  wire logic                                addrSelectBit1,
   input  wire logic                                addrSelectBit2,
   output logic                                     alertOut,
   output logic                                     alertOe,
   output logic                                     irq,
   input  wire logic [sensor_eeprom_pkg::AV_AW-1:0] address,
   input  wire logic                                read,
   input  wire logic                                write,
   input  wire logic [31:0]                         writedata,
   output logic      [31:0]                         readdata,
   output logic                                     waitrequest
);
   import sensor_eeprom_pkg::*;

   typedef enum logic [2:0] {ST_IDLE, ST_RECV, ST_ACK, ST_SEND, ST_CHECK} link_state_t;

   link_state_t  state;
   target_t      target;
   target_t      decodeTarget;
   logic         sclS, sdaS, sclPrev, sdaPrev;
   logic [2:0]   selS;
   logic [2:0]   memChipEnable;
   logic         sclRise, sclFall, startCond, stopCond;
   logic [2:0]   bitCnt;
   logic [7:0]   shiftIn, rxByte, txByte, nextTx;
   logic         isAddr, rwRead, ackNow, ackDecision, phase;
   logic [1:0]   byteIdx, nextIdx;
   logic         rxDone, rxData, loadTx;
   logic         typeSensor, typeMem, typeProt, addrHit;
   logic [7:0]   mem [0:MEM_DEPTH-1];
   logic [7:0]   memAddr;
   logic         memWrite, memReject;
   logic         revLock, permLock, protAny, protEvent, rxProt;
   logic [7:0]   pointer, wordHi;
   logic [15:0]  sensorCfg, wrWord;
   logic [9:0]   upper, lower, crit, tempVal;
   logic         sensorWr, evtClear;
   logic         aboveUp, belowLo, overCrit, cond, condPrev, eventLatch, active;
   logic         cfgEn, cfgInt, cfgCritOnly;
   logic [ST_W-1:0] status, mask;
   logic         busAck;
   logic [31:0]  regValue;

   function automatic logic isLocked(input logic [7:0] a, input logic prot);
      isLocked = MEM_WRITE_CONTROL | (prot && a <= LOCK_TOP);
   endfunction

   // slow pins and straps pass the three-stage agreement filter; at 100 MHz
   // its few cycles of delay are small beside a 400 kHz half period
   pin_filter #(.W(5), .INIT(5'h1f)) pins (
      .clk  (clk),
      .rstn (rstn),
      .din  ({addrSelectBit2, addrSelectBit1, addrSelectBit0, sdaIn, scl}),
      .dout ({selS, sdaS, sclS})
   );

   assign memChipEnable = selS;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         sclPrev <= 1'b1;
         sdaPrev <= 1'b1;
      end else begin
         sclPrev <= sclS;
         sdaPrev <= sdaS;
      end
   end

   assign sclRise   = sclS & ~sclPrev;
   assign sclFall   = ~sclS & sclPrev;
   assign startCond = sclS & sclPrev & sdaPrev & ~sdaS;
   assign stopCond  = sclS & sclPrev & ~sdaPrev & sdaS;
   assign rxByte    = {shiftIn[6:0], sdaS};
   assign rxDone    = (state == ST_RECV) && sclRise && (bitCnt == 3'h7);
   assign rxData    = rxDone && !isAddr;
   assign nextIdx   = (byteIdx == 2'h3) ? 2'h3 : byteIdx + 2'h1;

   // each target decodes its own code with the strapped bits
   assign typeSensor = (rxByte[7:4] == TYPE_SENSOR) && (rxByte[3:1] == selS);
   assign typeMem    = (rxByte[7:4] == TYPE_MEM) && (rxByte[3:1] == memChipEnable);
   assign typeProt   = (rxByte[7:4] == TYPE_PROT) && (rxByte[3:1] == memChipEnable);
   assign addrHit    = typeSensor | typeMem | typeProt;

   always_comb begin
      if (typeMem) begin
         decodeTarget = TGT_MEM;
      end else if (typeProt) begin
         decodeTarget = TGT_PROT;
      end else begin
         decodeTarget = TGT_SENSOR;
      end
   end

   always_comb begin
      if (isAddr) begin
         ackDecision = addrHit;
      end else begin
         unique case (target)
            TGT_MEM:    ackDecision = (byteIdx == 2'h0) || !isLocked(memAddr, protAny);
            TGT_PROT:   ackDecision = !permLock && (rxByte == PROT_SET_REV ||
                                      rxByte == PROT_SET_PERM || rxByte == PROT_CLEAR);
            TGT_SENSOR: ackDecision = 1'b1;
         endcase
      end
   end

   // link state machine: bits sampled on scl rise, sda changed after scl fall
   always_ff @(posedge clk) begin
      if (!rstn) begin
         state   <= ST_IDLE;
         bitCnt  <= 3'h0;
         shiftIn <= 8'h00;
         isAddr  <= 1'b0;
         rwRead  <= 1'b0;
         ackNow  <= 1'b0;
         phase   <= 1'b0;
         sdaOe   <= 1'b0;
         txByte  <= 8'hff;
         byteIdx <= 2'h0;
         target  <= TGT_SENSOR;
      end else if (startCond) begin
         state  <= ST_RECV;
         bitCnt <= 3'h0;
         isAddr <= 1'b1;
         phase  <= 1'b0;
         sdaOe  <= 1'b0;
      end else if (stopCond) begin
         state <= ST_IDLE;
         sdaOe <= 1'b0;
      end else begin
         unique case (state)
            ST_IDLE: begin
            end
            ST_RECV: if (sclRise) begin
               shiftIn <= rxByte;
               bitCnt  <= bitCnt + 3'h1;
               if (bitCnt == 3'h7) begin
                  state  <= ST_ACK;
                  ackNow <= ackDecision;
                  if (isAddr) begin
                     target  <= decodeTarget;
                     rwRead  <= rxByte[0];
                     byteIdx <= 2'h0;
                     isAddr  <= 1'b0;
                  end else begin
                     byteIdx <= nextIdx;
                  end
               end
            end
            ST_ACK: if (sclFall) begin
               if (!phase) begin
                  sdaOe <= ackNow;
                  phase <= ackNow;
                  if (!ackNow) begin
                     state <= ST_IDLE;
                  end
               end else begin
                  phase  <= 1'b0;
                  bitCnt <= 3'h0;
                  if (rwRead) begin
                     state   <= ST_SEND;
                     txByte  <= nextTx;
                     sdaOe   <= ~nextTx[7];
                     byteIdx <= byteIdx + 2'h1;
                  end else begin
                     state <= ST_RECV;
                     sdaOe <= 1'b0;
                  end
               end
            end
            ST_SEND: if (sclFall) begin
               bitCnt <= bitCnt + 3'h1;
               txByte <= {txByte[6:0], 1'b1};
               sdaOe  <= (bitCnt == 3'h7) ? 1'b0 : ~txByte[6];
               if (bitCnt == 3'h7) begin
                  state <= ST_CHECK;
               end
            end
            ST_CHECK: if (sclRise) begin
               if (sdaS) begin
                  state <= ST_IDLE;
               end else begin
                  phase <= 1'b1;
               end
            end else if (sclFall && phase) begin
               phase   <= 1'b0;
               state   <= ST_SEND;
               txByte  <= nextTx;
               sdaOe   <= ~nextTx[7];
               byteIdx <= byteIdx + 2'h1;
            end
         endcase
      end
   end

   assign sdaOut = 1'b0;
   assign loadTx = sclFall && phase && ((state == ST_ACK && rwRead) || state == ST_CHECK);

   // read data never waits on a conversion: the last result is always served
   always_comb begin
      wrWord = 16'h0000;
      unique case (target)
         TGT_MEM:    nextTx = mem[memAddr];
         TGT_PROT:   nextTx = {6'h00, permLock, revLock};
         TGT_SENSOR: begin
            unique case (pointer)
               PTR_CONFIG: wrWord = sensorCfg;
               PTR_UPPER:  wrWord = {6'h00, upper};
               PTR_LOWER:  wrWord = {6'h00, lower};
               PTR_CRIT:   wrWord = {6'h00, crit};
               PTR_TEMP:   wrWord = {overCrit, aboveUp, belowLo, 3'h0, tempVal};
               default:    wrWord = 16'h0000;
            endcase
            nextTx = byteIdx[0] ? wrWord[7:0] : wrWord[15:8];
         end
      endcase
   end

   // memory array: 256 bytes, address advances per byte read or accepted write; a rejected write leaves it
   assign memWrite  = rxData && target == TGT_MEM && byteIdx != 2'h0 &&
                      !isLocked(memAddr, protAny);
   assign memReject = rxData && target == TGT_MEM && byteIdx != 2'h0 &&
                      isLocked(memAddr, protAny);

   always_ff @(posedge clk) begin
      if (!rstn) begin
         memAddr <= 8'h00;
      end else if (rxData && target == TGT_MEM) begin
         if (byteIdx == 2'h0) begin
            memAddr <= rxByte;
         end else if (memWrite) begin
            memAddr <= memAddr + 8'h01;
         end
      end else if (loadTx && target == TGT_MEM) begin
         memAddr <= memAddr + 8'h01;
      end
   end

   // array contents are not reset, like nonvolatile storage
   always_ff @(posedge clk) begin
      if (memWrite) begin
         mem[memAddr] <= rxByte;
      end
   end

   // protection: a permanent lock can never be undone except by power cycle
   assign rxProt    = rxData && target == TGT_PROT && byteIdx == 2'h0 && !permLock;
   assign protEvent = rxProt && (rxByte == PROT_SET_REV || rxByte == PROT_SET_PERM);
   assign protAny   = revLock | permLock;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         revLock  <= 1'b0;
         permLock <= 1'b0;
      end else if (rxProt) begin
         if (rxByte == PROT_SET_REV) begin
            revLock <= 1'b1;
         end else if (rxByte == PROT_CLEAR) begin
            revLock <= 1'b0;
         end
         if (rxByte == PROT_SET_PERM) begin
            permLock <= 1'b1;
         end
      end
   end

   // sensor registers: pointer byte, then high and low byte of the word
   assign sensorWr = rxData && target == TGT_SENSOR && byteIdx == 2'h2;
   assign evtClear = sensorWr && pointer == PTR_CONFIG && rxByte[CFG_EVT_CLEAR];

   always_ff @(posedge clk) begin
      if (!rstn) begin
         pointer <= 8'h00;
         wordHi  <= 8'h00;
         sensorCfg <= CFG_RESET;
         upper   <= LIMIT_RESET;
         lower   <= LIMIT_RESET;
         crit    <= LIMIT_RESET;
      end else if (rxData && target == TGT_SENSOR) begin
         if (byteIdx == 2'h0) begin
            pointer <= rxByte;
         end else if (byteIdx == 2'h1) begin
            wordHi <= rxByte;
         end else if (byteIdx == 2'h2) begin
            if (pointer == PTR_CONFIG) begin
               sensorCfg <= {wordHi, rxByte} & CFG_WMASK;
            end else if (pointer == PTR_UPPER) begin
               upper <= {wordHi[1:0], rxByte};
            end else if (pointer == PTR_LOWER) begin
               lower <= {wordHi[1:0], rxByte};
            end else if (pointer == PTR_CRIT) begin
               crit <= {wordHi[1:0], rxByte};
            end
         end
      end
   end

   // alert: limits compared as signed quarter-degree Celsius values
   assign cfgEn       = sensorCfg[CFG_EVT_EN];
   assign cfgInt      = sensorCfg[CFG_INT_MODE];
   assign cfgCritOnly = sensorCfg[CFG_CRIT_ONLY];
   assign aboveUp     = $signed(tempVal) > $signed(upper);
   assign belowLo     = $signed(tempVal) < $signed(lower);
   assign overCrit    = $signed(tempVal) > $signed(crit);
   assign cond        = cfgCritOnly ? overCrit : (aboveUp | belowLo | overCrit);
   assign active      = cfgEn & (cfgInt ? eventLatch : cond);

   always_ff @(posedge clk) begin
      if (!rstn) begin
         condPrev   <= 1'b0;
         eventLatch <= 1'b0;
         alertOe    <= 1'b0;
      end else begin
         condPrev <= cond;
         // a new event in the clearing cycle is kept
         if (cond && !condPrev) begin
            eventLatch <= 1'b1;
         end else if (evtClear) begin
            eventLatch <= 1'b0;
         end
         alertOe <= active;
      end
   end

   assign alertOut = 1'b0;

   // avalon slave: one wait cycle, read data registered
   assign waitrequest = (read | write) & ~busAck;

   always_comb begin
      unique case (address)
         REG_STATUS: regValue = {29'h0, status};
         REG_MASK:   regValue = {29'h0, mask};
         REG_TEMP:   regValue = {22'h0, tempVal};
         REG_STATE:  regValue = {28'h0, permLock, revLock, alertOe, state != ST_IDLE};
         default:    regValue = 32'h0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         busAck   <= 1'b0;
         readdata <= 32'h0;
      end else begin
         busAck <= (read | write) & ~busAck;
         if (read && !busAck) begin
            readdata <= regValue;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         mask    <= '0;
         tempVal <= TEMP_RESET;
      end else if (write && !waitrequest) begin
         if (address == REG_MASK) begin
            mask <= writedata[ST_W-1:0];
         end
         if (address == REG_TEMP) begin
            tempVal <= writedata[9:0];
         end
      end
   end

   // write-one-to-clear; a new event beats the clear
   always_ff @(posedge clk) begin
      if (!rstn) begin
         status <= '0;
         irq    <= 1'b0;
      end else begin
         status <= (status & ~((write && !waitrequest && address == REG_STATUS) ?
                   writedata[ST_W-1:0] : {ST_W{1'b0}}))
                   | {protEvent, memReject, active & ~alertOe};
         irq    <= |(status & mask);
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   addr_nack_a: assert property (rxDone && isAddr && !addrHit |=> !ackNow)
      else $error("unmatched address acknowledged");
   sensor_code_a: assert property (rxDone && isAddr && typeSensor |=> target == TGT_SENSOR)
      else $error("sensor code not routed to sensor");
   mem_code_a: assert property (rxDone && isAddr && typeMem |=> target == TGT_MEM)
      else $error("memory code not routed to memory");
   prot_code_a: assert property (rxDone && isAddr && typeProt |=> target == TGT_PROT)
      else $error("protection code not routed");
   lock_write_a: assert property (rxData && target == TGT_MEM && byteIdx != 2'h0 &&
      protAny && memAddr <= LOCK_TOP |=> status[ST_REJECT] && !ackNow)
      else $error("locked location accepted a write");
   perm_hold_a: assert property (permLock |=> permLock)
      else $error("permanent lock released");
   comp_mode_a: assert property ((cfgEn && !cfgInt && cond) [*2] |-> alertOe)
      else $error("comparator alert not following condition");
   crit_only_a: assert property ((cfgCritOnly && !cfgInt && !overCrit) [*2] |-> !alertOe)
      else $error("alert without critical condition");
   int_latch_a: assert property (cfgEn && cfgInt && cond && !condPrev ##1 cfgEn && cfgInt
      |=> alertOe)
      else $error("interrupt alert not raised");
   bus_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("bus access not answered in one cycle");

   mem_hit_c: cover property (rxDone && isAddr && typeMem);
   reject_c: cover property (memReject);
   alert_c: cover property ($rose(alertOe));
   read_c: cover property (loadTx && target == TGT_SENSOR);
endmodule

// file: tb/i2c_link_master.sv
`timescale 1ns/10ps
module i2c_link_master (
   input  wire logic clk,
   input  wire logic sdaLine,
   output logic      scl,
   output logic      sdaDrive
);
   // idle: clock parked high, data released to the pull-up
   initial begin
      scl = 1'b1;
      sdaDrive = 1'b1;
   end

   task automatic pause(input int n);
      repeat (n) @(posedge clk);
   endtask

   // outside start and stop, data moves only mid-low so the slave never sees a false start or stop
   task automatic start();
      pause(4);
      sdaDrive <= 1'b1;
      pause(4);
      scl <= 1'b1;
      pause(8);
      sdaDrive <= 1'b0;
      pause(8);
      scl <= 1'b0;
   endtask

   task automatic stop();
      pause(4);
      sdaDrive <= 1'b0;
      pause(4);
      scl <= 1'b1;
      pause(8);
      sdaDrive <= 1'b1;
      pause(8);
   endtask

   // 160 ns link period; the line is read late in the high phase
   task automatic xferBit(input logic b, output logic r);
      pause(4);
      sdaDrive <= b;
      pause(4);
      scl <= 1'b1;
      pause(7);
      @(negedge clk);
      r = sdaLine;
      @(posedge clk);
      scl <= 1'b0;
   endtask

   task automatic sendByte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) xferBit(b[i], r);
      xferBit(1'b1, r);
      ack = ~r;
   endtask

   task automatic getByte(input logic ackIt, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) xferBit(1'b1, b[i]);
      xferBit(~ackIt, r);
   endtask
endmodule

// file: tb/sensor_eeprom_bus_decode_bench.sv
`timescale 1ns/10ps
module sensor_eeprom_bus_decode_bench;
   import sensor_eeprom_pkg::*;
   logic        clk, rstn, scl, sdaDrive, sdaOut, sdaOe, read, write;
   logic        alertOut, alertOe, irq, waitrequest;
   logic [2:0]  straps;
   logic [3:0]  address;
   logic [31:0] writedata, readdata;
   int          err_count, n_tests;
   wire logic   sdaLine = sdaDrive & ~sdaOe; // pull-up: any low driver wins

   sensor_eeprom_bus_decode u_sensor_eeprom_bus_decode (
      .clk(clk), .rstn(rstn), .scl(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .addrSelectBit0(straps[0]), .addrSelectBit1(straps[1]), .addrSelectBit2(straps[2]),
      .alertOut(alertOut), .alertOe(alertOe), .irq(irq), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));
   i2c_link_master u_i2c_link_master (.clk(clk), .sdaLine(sdaLine), .scl(scl),
      .sdaDrive(sdaDrive));

   always #5 clk = ~clk;

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic avAccess(input logic wr, input logic [3:0] a, input logic [31:0] d,
                           output logic [31:0] q);
      int i;
      read <= ~wr;
      write <= wr;
      address <= a;
      writedata <= d;
      i = 0;
      // waitrequest and readdata are read as they stood at the edge
      do begin
         @(posedge clk);
         i++;
      end while (waitrequest !== 1'b0 && i < 20);
      q = readdata;
      if (i >= 20) begin
         err_count++;
         results();
      end
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
   endtask

   task automatic avWr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      avAccess(1'b1, a, d, q);
   endtask

   task automatic avChk(input string n, input logic [3:0] a, input logic [31:0] e);
      logic [31:0] q;
      avAccess(1'b0, a, 32'h0, q);
      check(n, q, e);
   endtask

   // acks holds {address, byte0, byte1, byte2}
   task automatic frame(input logic [6:0] dev, input int n, input logic [7:0] b0,
                        input logic [7:0] b1, input logic [7:0] b2, output logic [3:0] acks);
      logic [7:0] b [3];
      logic       a;
      b = '{b0, b1, b2};
      acks = 4'h0;
      u_i2c_link_master.start();
      u_i2c_link_master.sendByte({dev, 1'b0}, a);
      acks[3] = a;
      for (int i = 0; i < n; i++) begin
         u_i2c_link_master.sendByte(b[i], a);
         acks[2-i] = a;
      end
      u_i2c_link_master.stop();
   endtask

   task automatic rdFrame(input logic [6:0] dev, input logic [7:0] ptr, output logic [15:0] w);
      logic a;
      u_i2c_link_master.start();
      u_i2c_link_master.sendByte({dev, 1'b0}, a);
      u_i2c_link_master.sendByte(ptr, a);
      u_i2c_link_master.start();
      u_i2c_link_master.sendByte({dev, 1'b1}, a);
      u_i2c_link_master.getByte(1'b1, w[15:8]);
      u_i2c_link_master.getByte(1'b0, w[7:0]);
      u_i2c_link_master.stop();
   endtask

   task automatic testReset();
      avChk("status", REG_STATUS, 32'h0);
      avChk("mask", REG_MASK, 32'h0);
      avChk("temp", REG_TEMP, 32'h0);
      avChk("state", REG_STATE, 32'h0);
      avWr(4'h2, 32'hffffffff);
      avChk("unmapped", 4'h2, 32'h0);
      check("idle pins", {sdaOe, alertOut, alertOe, irq}, 4'h0);
      $display("test reset done");
   endtask

   task automatic testAddr();
      logic [3:0] acks;
      logic [3:0] codes [3] = '{TYPE_SENSOR, TYPE_MEM, TYPE_PROT};
      straps <= 3'b010;
      repeat (8) @(posedge clk);
      foreach (codes[i]) begin
         frame({codes[i], straps}, 0, 8'h00, 8'h00, 8'h00, acks);
         check("typed ack", acks[3], 1'b1);
      end
      frame({4'h5, straps}, 0, 8'h00, 8'h00, 8'h00, acks);
      check("foreign type", acks[3], 1'b0);
      frame({TYPE_MEM, straps ^ 3'b100}, 0, 8'h00, 8'h00, 8'h00, acks);
      check("strap mismatch", acks[3], 1'b0);
      $display("test addressing done");
   endtask

   task automatic testProt();
      logic [3:0]  acks;
      logic [15:0] w;
      logic [6:0]  mem, prot;
      mem = {TYPE_MEM, straps};
      prot = {TYPE_PROT, straps};
      frame(prot, 1, PROT_SET_REV, 8'h00, 8'h00, acks);
      check("set reversible", acks[3:2], 2'b11);
      frame(mem, 2, 8'h7f, 8'h11, 8'h00, acks);
      check("locked write", acks[3:1], 3'b110);
      frame(mem, 2, 8'h80, 8'h5a, 8'h00, acks);
      check("upper write", acks[3:1], 3'b111);
      rdFrame(mem, 8'h80, w);
      check("upper read", w[15:8], 8'h5a);
      avChk("state reversible", REG_STATE, 32'h4);
      avChk("status reject", REG_STATUS, 32'h6);
      avWr(REG_STATUS, 32'h7);
      frame(prot, 1, PROT_CLEAR, 8'h00, 8'h00, acks);
      check("clear reversible", acks[3:2], 2'b11);
      frame(mem, 2, 8'h00, 8'h33, 8'h00, acks);
      check("unlocked write", acks[3:1], 3'b111);
      rdFrame(mem, 8'h00, w);
      check("lower read", w[15:8], 8'h33);
      frame(prot, 1, PROT_SET_PERM, 8'h00, 8'h00, acks);
      check("set permanent", acks[3:2], 2'b11);
      frame(prot, 1, PROT_CLEAR, 8'h00, 8'h00, acks);
      check("clear refused", acks[3:2], 2'b10);
      frame(mem, 2, 8'h00, 8'h44, 8'h00, acks);
      check("permanent lock", acks[3:1], 3'b110);
      avChk("state permanent", REG_STATE, 32'h8);
      avWr(REG_STATUS, 32'h7);
      $display("test protection done");
   endtask

   task automatic testAlert();
      logic [3:0]  acks;
      logic [15:0] w;
      logic [6:0]  sen;
      sen = {TYPE_SENSOR, straps};
      avWr(REG_MASK, 32'h1);
      avWr(REG_TEMP, 32'h4);
      repeat (3) @(posedge clk);
      check("comparator alert", {alertOut, alertOe, irq}, 3'b011);
      avChk("status alert", REG_STATUS, 32'h1);
      rdFrame(sen, PTR_TEMP, w);
      check("temp word", w, 16'hc004);
      frame(sen, 3, PTR_CRIT, 8'h00, 8'h08, acks);
      frame(sen, 3, PTR_CONFIG, 8'h00, 8'h0c, acks);
      repeat (3) @(posedge clk);
      check("critical only", alertOe, 1'b0);
      frame(sen, 3, PTR_CONFIG, 8'h00, 8'h09, acks);
      avWr(REG_TEMP, 32'h0);
      repeat (3) @(posedge clk);
      check("latched event", alertOe, 1'b1);
      frame(sen, 3, PTR_CONFIG, 8'h00, 8'h29, acks);
      repeat (3) @(posedge clk);
      check("latch cleared", alertOe, 1'b0);
      avWr(REG_MASK, 32'h0);
      repeat (3) @(posedge clk);
      check("masked irq", irq, 1'b0);
      avWr(REG_STATUS, 32'h7);
      avChk("status clear", REG_STATUS, 32'h0);
      $display("test alert done");
   endtask

   initial begin
      clk = 1'b0;
      rstn = 1'b0;
      read = 1'b0;
      write = 1'b0;
      address = 4'h0;
      writedata = 32'h0;
      straps = 3'b101;
      err_count = 0;
      n_tests = 0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      // the pin filters need a few cycles to flush before any traffic
      repeat (6) @(posedge clk);
      testReset();
      testAddr();
      testProt();
      testAlert();
      results();
   end
endmodule
